// file: rtl/rtcss_serial_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "rtcss_regs.vh"

module rtcss_serial_slave #(
  parameter [6:0] SLAVE_ADDR = 7'h2A // arbitrary value
) (
  input wire mclk,
  input wire nrst,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOen,
  output wire primaryIrqOut,
  output wire primaryIrqOen,
  output wire waveOrSecondaryIrqOut,
  output wire waveOrSecondaryIrqOen,
  input wire squareWaveIn,
  input wire oscStoppedIn,
  input wire alarm1Match,
  input wire alarm2Match,
  output wire oscRun,
  output wire [1:0] rateSelect,
  output wire [3:0] regAddr,
  input wire [7:0] regRdData,
  output wire [3:0] regWrAddr,
  output wire [7:0] regWrData,
  output wire regWrPulse
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_RXACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_TXACK = 3'h4;
  localparam [2:0] ST_TXNEXT = 3'h5;

  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_PTR = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  wire sclLvl;
  wire sdaLvl;
  wire waveLvl;
  wire oscStopLvl;

  reg sclPrev_ff;
  reg sdaPrev_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] bitCnt_ff;
  reg [3:0] nxt_bitCnt;
  reg [7:0] shift_ff;
  reg [7:0] nxt_shift;
  reg [1:0] phase_ff;
  reg [1:0] nxt_phase;
  reg readMode_ff;
  reg nxt_readMode;
  reg sdaDrive_ff;
  reg nxt_sdaDrive;
  reg [3:0] ptr_ff;
  reg [3:0] nxt_ptr;
  reg wrPulse;

  reg [7:0] ctrl_ff;
  reg [7:0] nxt_ctrl;
  reg osf_ff;
  reg nxt_osf;
  reg a1f_ff;
  reg nxt_a1f;
  reg a2f_ff;
  reg nxt_a2f;

  reg wrPulse_ff;
  reg [3:0] wrAddr_ff;
  reg [7:0] wrData_ff;
  reg primaryOen_ff;
  reg secondaryOen_ff;

  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire statusWr;
  wire ctrlWr;
  wire [7:0] statusByte;
  reg [7:0] rdByte;

  rtcss_in_sync #(
    .INIT(1'b1)
  ) u_sclSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(sclIn),
    .levelOut(sclLvl)
  );

  rtcss_in_sync #(
    .INIT(1'b1)
  ) u_sdaSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(sdaIn),
    .levelOut(sdaLvl)
  );

  rtcss_in_sync #(
    .INIT(1'b1)
  ) u_waveSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(squareWaveIn),
    .levelOut(waveLvl)
  );

  rtcss_in_sync #(
    .INIT(1'b0)
  ) u_oscSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(oscStoppedIn),
    .levelOut(oscStopLvl)
  );

  assign sclRise = sclLvl & ~sclPrev_ff;
  assign sclFall = ~sclLvl & sclPrev_ff;
  // both samples must see the clock high so a clock edge is not a condition
  assign startCond = sclLvl & sclPrev_ff & sdaPrev_ff & ~sdaLvl;
  assign stopCond = sclLvl & sclPrev_ff & ~sdaPrev_ff & sdaLvl;

  assign statusWr = wrPulse & (ptr_ff == `RTCSS_ADDR_STATUS);
  assign ctrlWr = wrPulse & (ptr_ff == `RTCSS_ADDR_CTRL);

  // unused bits are tied to zero on read
  assign statusByte = {osf_ff, 5'h00, a2f_ff, a1f_ff};

  always @*
  begin
    if (ptr_ff == `RTCSS_ADDR_STATUS)
      rdByte = statusByte;
    else if (ptr_ff == `RTCSS_ADDR_CTRL)
      rdByte = ctrl_ff;
    else
      rdByte = regRdData;
  end

  always @*
  begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_phase = phase_ff;
    nxt_readMode = readMode_ff;
    nxt_sdaDrive = sdaDrive_ff;
    nxt_ptr = ptr_ff;
    wrPulse = 1'b0;
    // a repeated start restarts framing from any state
    if (startCond)
    begin
      nxt_state = ST_RX;
      nxt_bitCnt = 4'h0;
      nxt_phase = PH_ADDR;
      nxt_sdaDrive = 1'b0;
    end
    else if (stopCond)
    begin
      nxt_state = ST_IDLE;
      nxt_sdaDrive = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_RX:
        begin
          if (sclRise && (bitCnt_ff != `RTCSS_BYTE_BITS))
          begin
            nxt_shift = {shift_ff[6:0], sdaLvl};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end
          else if (sclFall && (bitCnt_ff == `RTCSS_BYTE_BITS))
          begin
            if (phase_ff == PH_ADDR)
            begin
              if (shift_ff[7:1] == SLAVE_ADDR)
              begin
                nxt_readMode = shift_ff[0];
                nxt_sdaDrive = 1'b1;
                nxt_state = ST_RXACK;
              end
              else
                nxt_state = ST_IDLE;
            end
            else
            begin
              nxt_sdaDrive = 1'b1;
              nxt_state = ST_RXACK;
              if (phase_ff == PH_PTR)
                nxt_ptr = shift_ff[3:0];
              else
              begin
                wrPulse = 1'b1;
                nxt_ptr = ptr_ff + 4'h1;
              end
            end
          end
        end
        ST_RXACK:
        begin
          // held low from one falling clock to the next covers the high phase
          if (sclFall)
          begin
            if ((phase_ff == PH_ADDR) && readMode_ff)
            begin
              nxt_state = ST_TX;
              nxt_shift = rdByte;
              nxt_sdaDrive = ~rdByte[7];
              nxt_bitCnt = 4'h1;
            end
            else
            begin
              nxt_state = ST_RX;
              nxt_sdaDrive = 1'b0;
              nxt_bitCnt = 4'h0;
              nxt_phase = (phase_ff == PH_ADDR) ? PH_PTR : PH_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt_ff != `RTCSS_BYTE_BITS)
            begin
              nxt_sdaDrive = ~shift_ff[6];
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_bitCnt = bitCnt_ff + 4'h1;
            end
            else
            begin
              nxt_sdaDrive = 1'b0;
              nxt_state = ST_TXACK;
            end
          end
        end
        ST_TXACK:
        begin
          if (sclRise)
          begin
            nxt_ptr = ptr_ff + 4'h1;
            // a refused byte ends the read with the line released
            if (sdaLvl)
              nxt_state = ST_IDLE;
            else
              nxt_state = ST_TXNEXT;
          end
        end
        ST_TXNEXT:
        begin
          if (sclFall)
          begin
            nxt_state = ST_TX;
            nxt_shift = rdByte;
            nxt_sdaDrive = ~rdByte[7];
            nxt_bitCnt = 4'h1;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
          nxt_sdaDrive = 1'b0;
        end
      endcase
    end
  end

  always @*
  begin
    nxt_ctrl = ctrl_ff;
    if (ctrlWr)
      nxt_ctrl = shift_ff & `RTCSS_CTRL_MASK;
    nxt_osf = osf_ff;
    if (statusWr && !shift_ff[`RTCSS_ST_OSF])
      nxt_osf = 1'b0;
    // set after clear so a stop in the clearing cycle is kept
    if (oscStopLvl)
      nxt_osf = 1'b1;
    if (ctrl_ff[`RTCSS_CT_OSC_DISABLE_CONTROL])
      nxt_osf = 1'b1;
    nxt_a1f = a1f_ff;
    if (statusWr && !shift_ff[`RTCSS_ST_A1F])
      nxt_a1f = 1'b0;
    if (alarm1Match)
      nxt_a1f = 1'b1;
    nxt_a2f = a2f_ff;
    if (statusWr && !shift_ff[`RTCSS_ST_A2F])
      nxt_a2f = 1'b0;
    if (alarm2Match)
      nxt_a2f = 1'b1;
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      phase_ff <= PH_ADDR;
      readMode_ff <= 1'b0;
      sdaDrive_ff <= 1'b0;
      ptr_ff <= `RTCSS_PTR_RESET;
      ctrl_ff <= `RTCSS_CTRL_RESET;
      osf_ff <= `RTCSS_OSF_RESET;
      a1f_ff <= `RTCSS_AF_RESET;
      a2f_ff <= `RTCSS_AF_RESET;
      wrPulse_ff <= 1'b0;
      wrAddr_ff <= `RTCSS_PTR_RESET;
      wrData_ff <= 8'h00;
      primaryOen_ff <= 1'b1;
      secondaryOen_ff <= 1'b1;
    end
    else
    begin
      sclPrev_ff <= sclLvl;
      sdaPrev_ff <= sdaLvl;
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      phase_ff <= nxt_phase;
      readMode_ff <= nxt_readMode;
      sdaDrive_ff <= nxt_sdaDrive;
      ptr_ff <= nxt_ptr;
      ctrl_ff <= nxt_ctrl;
      osf_ff <= nxt_osf;
      a1f_ff <= nxt_a1f;
      a2f_ff <= nxt_a2f;
      wrPulse_ff <= wrPulse & ~statusWr & ~ctrlWr;
      if (wrPulse)
      begin
        wrAddr_ff <= ptr_ff;
        wrData_ff <= shift_ff;
      end
      primaryOen_ff <= ~((a1f_ff & ctrl_ff[`RTCSS_CT_FIRST_ALARM_IRQ_ENABLE])
        | (a2f_ff & ctrl_ff[`RTCSS_CT_SECOND_ALARM_IRQ_ENABLE]
        & ~ctrl_ff[`RTCSS_CT_IRQ_ROUTING_SELECT]));
      if (ctrl_ff[`RTCSS_CT_IRQ_ROUTING_SELECT])
        secondaryOen_ff <= ~(a2f_ff & ctrl_ff[`RTCSS_CT_SECOND_ALARM_IRQ_ENABLE]);
      else
        secondaryOen_ff <= waveLvl;
    end
  end

  // open-drain pins only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOen = ~sdaDrive_ff;
  assign primaryIrqOut = 1'b0;
  assign primaryIrqOen = primaryOen_ff;
  assign waveOrSecondaryIrqOut = 1'b0;
  assign waveOrSecondaryIrqOen = secondaryOen_ff;

  assign oscRun = ~ctrl_ff[`RTCSS_CT_OSC_DISABLE_CONTROL];
  assign rateSelect = {ctrl_ff[`RTCSS_CT_RS_HI], ctrl_ff[`RTCSS_CT_RS_LO]};
  assign regAddr = ptr_ff;
  assign regWrAddr = wrAddr_ff;
  assign regWrData = wrData_ff;
  assign regWrPulse = wrPulse_ff;

endmodule // rtcss_serial_slave

`default_nettype wire

// file: rtl/rtcss_regs.vh
`ifndef RTCSS_REGS_VH
`define RTCSS_REGS_VH

// register pointer values
`define RTCSS_ADDR_CTRL 4'hE
`define RTCSS_ADDR_STATUS 4'hF

// control register layout and reset value
`define RTCSS_CT_OSC_DISABLE_CONTROL 7
`define RTCSS_CT_RS_HI 4
`define RTCSS_CT_RS_LO 3
`define RTCSS_CT_IRQ_ROUTING_SELECT 2
`define RTCSS_CT_SECOND_ALARM_IRQ_ENABLE 1
`define RTCSS_CT_FIRST_ALARM_IRQ_ENABLE 0
`define RTCSS_CTRL_RESET 8'h18
`define RTCSS_CTRL_MASK 8'h9F

// status register layout and reset values
`define RTCSS_ST_OSF 7
`define RTCSS_ST_A2F 1
`define RTCSS_ST_A1F 0
`define RTCSS_OSF_RESET 1'b1
`define RTCSS_AF_RESET 1'b0

// serial framing
`define RTCSS_BYTE_BITS 4'h8
`define RTCSS_PTR_RESET 4'h0

`endif

// file: rtl/rtcss_in_sync.v
`timescale 1ns/1ps
`default_nettype none

module rtcss_in_sync #(
  parameter [0:0] INIT = 1'b1
) (
  input wire mclk,
  input wire nrst,
  input wire asyncIn,
  output wire levelOut
);

  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg level_ff;

  // a change is accepted only once stages two and three agree
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
      stage3_ff <= INIT;
      level_ff <= INIT;
    end
    else
    begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff)
        level_ff <= stage3_ff;
    end
  end

  assign levelOut = level_ff;

endmodule // rtcss_in_sync

`default_nettype wire

// file: testbench/rtcss_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcss_regs.vh"
module rtcss_assertions (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaOen,
  input wire logic primaryIrqOen,
  input wire logic alarm1Match,
  input wire logic alarm2Match,
  input wire logic oscRun,
  input wire logic [3:0] regAddr,
  input wire logic [3:0] regWrAddr,
  input wire logic regWrPulse
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic [3:0] fallCnt_ff;
  // cycles since the bus clock pin fell, saturating
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      fallCnt_ff <= 4'hF;
    else if ($fell(sclIn))
      fallCnt_ff <= 4'h0;
    else if (fallCnt_ff != 4'hF)
      fallCnt_ff <= fallCnt_ff + 4'h1;
  a_sda_after_fall: assert property ($changed(sdaOen) |-> fallCnt_ff inside {[2:8]})
    else $error("data drive moved outside clock low");
  a_ack_steady: assert property ($rose(sclIn) && !sdaOen |=> !sdaOen [*3])
    else $error("data released during clock high");
  a_wr_single: assert property (regWrPulse |=> !regWrPulse)
    else $error("write pulse longer than one cycle");
  a_wr_skips_own: assert property (regWrPulse |-> regWrAddr != `RTCSS_ADDR_CTRL
    && regWrAddr != `RTCSS_ADDR_STATUS)
    else $error("own register forwarded");
  a_ptr_advance: assert property (regWrPulse |-> regAddr == regWrAddr + 4'h1)
    else $error("pointer not advanced after write");
  a_osc_reset_run: assert property ($rose(nrst) |-> oscRun)
    else $error("oscillator stopped after reset");
  a_irq_clear_cause: assert property ($rose(primaryIrqOen) |-> !$past(sdaOen))
    else $error("primary irq released without a write");
  a_irq_set_cause: assert property ($fell(primaryIrqOen) |->
    $past(alarm1Match, 2) || $past(alarm2Match, 2) || !$past(sdaOen))
    else $error("primary irq asserted without cause");
endmodule // rtcss_assertions
bind rtcss_serial_slave rtcss_assertions u_rtcss_assertions (.mclk, .nrst,
  .sclIn, .sdaOen, .primaryIrqOen, .alarm1Match, .alarm2Match, .oscRun,
  .regAddr, .regWrAddr, .regWrPulse);
`default_nettype wire

// file: testbench/rtcss_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module rtcss_bus_master (
  input wire logic mclk,
  input wire logic sdaOen,
  output logic sclPin,
  output logic sdaPin
);
  logic sdaDrv;
  // open drain with pull-up: either party pulling low wins
  assign sdaPin = sdaDrv & sdaOen;
  initial
  begin
    sdaDrv = 1'b1;
    sclPin = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // data moves two cycles into the low phase to keep clear of the fall;
  // six low cycles let the device answer settle before the clock rises
  task automatic start();
    tick(2);
    sdaDrv = 1'b1;
    tick(4);
    sclPin = 1'b1;
    tick(4);
    sdaDrv = 1'b0;
    tick(4);
    sclPin = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sdaDrv = 1'b0;
    tick(4);
    sclPin = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(4);
  endtask
  task automatic bitx(input logic b, output logic got);
    tick(2);
    sdaDrv = b;
    tick(4);
    sclPin = 1'b1;
    tick(4);
    got = sdaPin;
    sclPin = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], g);
    bitx(1'b1, g);
    ack = !g;
  endtask
  task automatic getByte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, b[i]);
    bitx(last, g);
  endtask
endmodule // rtcss_bus_master
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [6:0] DEV = 7'h2A; // arbitrary bus address
  logic mclk, nrst, sqw, oscStop, al1, al2, sclPin, sdaPin, sdaOen;
  logic priOen, secOen, oscRun, wrPulse, a;
  logic [3:0] regAddr, wrAddr, wrAtSeen;
  logic [1:0] rate;
  logic [2:0] lowOut;
  logic [7:0] wrData, v, wrSeen;
  int n_fail, n_tests;
  wire logic [7:0] rdData = {4'hA, regAddr};
  rtcss_serial_slave u_rtcss_serial_slave (.mclk(mclk), .nrst(nrst),
    .sclIn(sclPin), .sdaIn(sdaPin), .sdaOut(lowOut[0]), .sdaOen(sdaOen),
    .primaryIrqOut(lowOut[1]), .primaryIrqOen(priOen),
    .waveOrSecondaryIrqOut(lowOut[2]),
    .waveOrSecondaryIrqOen(secOen), .squareWaveIn(sqw),
    .oscStoppedIn(oscStop), .alarm1Match(al1), .alarm2Match(al2),
    .oscRun(oscRun), .rateSelect(rate), .regAddr(regAddr),
    .regRdData(rdData),
    .regWrAddr(wrAddr), .regWrData(wrData), .regWrPulse(wrPulse));
  rtcss_bus_master u_rtcss_bus_master (.mclk(mclk), .sdaOen(sdaOen),
    .sclPin(sclPin), .sdaPin(sdaPin));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (wrPulse === 1'b1)
    begin
      wrSeen <= wrData;
      wrAtSeen <= wrAddr;
    end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ackChk(input logic [7:0] b);
    u_rtcss_bus_master.sendByte(b, a);
    chk("ack", 8'h01, {7'h0, a});
  endtask
  task automatic wrReg(input logic [3:0] p, input logic [7:0] d);
    u_rtcss_bus_master.start();
    ackChk({DEV, 1'b0});
    ackChk({4'h0, p});
    ackChk(d);
    u_rtcss_bus_master.stop();
  endtask
  task automatic rdReg(input logic [3:0] p, input logic [7:0] e);
    u_rtcss_bus_master.start();
    ackChk({DEV, 1'b0});
    ackChk({4'h0, p});
    u_rtcss_bus_master.start();
    ackChk({DEV, 1'b1});
    u_rtcss_bus_master.getByte(1'b1, v);
    chk("read", e, v);
    u_rtcss_bus_master.tick(6);
    chk("release", 8'h01, {7'h0, sdaOen});
    u_rtcss_bus_master.stop();
  endtask
  task automatic pulse(input int w, ref logic s);
    s = 1'b1;
    u_rtcss_bus_master.tick(w);
    s = 1'b0;
    u_rtcss_bus_master.tick(3);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    nrst = 1'b0;
    {sqw, oscStop, al1, al2} = 4'h0;
    repeat (16) @(posedge mclk);
    #1 nrst = 1'b1;
    u_rtcss_bus_master.tick(8);
    chk("osc run", 8'h01, {7'h0, oscRun});
    chk("rate reset", 8'h03, {6'h0, rate});
    chk("pins low", 8'h00, {5'h0, lowOut});
    rdReg(4'hF, 8'h80);
    wrReg(4'hF, 8'hFF);
    rdReg(4'hF, 8'h80);
    wrReg(4'hF, 8'h00);
    rdReg(4'hF, 8'h00);
    $display("reset test done");
    pulse(1, al1);
    rdReg(4'hF, 8'h01);
    chk("pri idle", 8'h01, {7'h0, priOen});
    wrReg(4'hE, 8'h01);
    chk("pri a1", 8'h00, {7'h0, priOen});
    chk("rate wr", 8'h00, {6'h0, rate});
    wrReg(4'hF, 8'h03);
    rdReg(4'hF, 8'h01);
    wrReg(4'hF, 8'h00);
    chk("pri clr", 8'h01, {7'h0, priOen});
    wrReg(4'hE, 8'h06);
    pulse(1, al2);
    chk("sec a2", 8'h00, {7'h0, secOen});
    chk("pri a2", 8'h01, {7'h0, priOen});
    wrReg(4'hE, 8'h02);
    chk("pri route", 8'h00, {7'h0, priOen});
    sqw = 1'b1;
    u_rtcss_bus_master.tick(8);
    chk("wave hi", 8'h01, {7'h0, secOen});
    sqw = 1'b0;
    u_rtcss_bus_master.tick(8);
    chk("wave lo", 8'h00, {7'h0, secOen});
    wrReg(4'hF, 8'h02);
    rdReg(4'hF, 8'h02);
    wrReg(4'hF, 8'h00);
    rdReg(4'hF, 8'h00);
    $display("alarm test done");
    wrReg(4'hE, 8'h80);
    chk("osc off", 8'h00, {7'h0, oscRun});
    wrReg(4'hE, 8'h00);
    rdReg(4'hF, 8'h80);
    wrReg(4'hF, 8'h00);
    pulse(10, oscStop);
    rdReg(4'hF, 8'h80);
    $display("osc test done");
    wrReg(4'h3, 8'h5A);
    chk("wr data", 8'h5A, wrSeen);
    chk("wr addr", 8'h03, {4'h0, wrAtSeen});
    rdReg(4'hC, 8'hAC);
    u_rtcss_bus_master.start();
    ackChk({DEV, 1'b1});
    u_rtcss_bus_master.getByte(1'b0, v);
    chk("seq d", 8'hAD, v);
    u_rtcss_bus_master.getByte(1'b1, v);
    chk("seq ctrl", 8'h00, v);
    u_rtcss_bus_master.stop();
    u_rtcss_bus_master.start();
    u_rtcss_bus_master.sendByte({DEV ^ 7'h01, 1'b0}, a);
    chk("no ack", 8'h00, {7'h0, a});
    u_rtcss_bus_master.stop();
    $display("bus test done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
